// >>> verilog/ckop_pkg.sv
// Constants, field layouts and carrier types of the clock output prescaler control.
// Assumes one 200 MHz core clock and a reference phase tick at each edge of the 16 MHz reference.
package ckop_pkg;

	// Register indices on the register port.
	localparam logic [5:0] CKOP_ADDR_CTRL0 = 6'h03;
	localparam logic [5:0] CKOP_ADDR_RXCTRL = 6'h0A;
	localparam logic [5:0] CKOP_ADDR_OSC = 6'h12;

	// Field positions in transceiver_control_zero.
	localparam int CKOP_RATE_LSB = 0;
	localparam int CKOP_SHA_BIT = 3;
	localparam int CKOP_DRV_LSB = 4;
	localparam int CKOP_PADIO_LSB = 6;
	// Field positions in the oscillator and receiver control registers.
	localparam int CKOP_TRIM_LSB = 0;
	localparam int CKOP_MODE_LSB = 4;
	localparam int CKOP_JIT_BIT = 5;

	// Reset values.
	localparam logic [2:0] CKOP_RATE_RST = 3'h1;
	localparam logic CKOP_SHA_RST = 1'b1;
	localparam logic [1:0] CKOP_DRV_RST = 2'h1;
	localparam logic [1:0] CKOP_PADIO_RST = 2'h0;
	localparam logic [3:0] CKOP_MODE_RST = 4'hF;
	localparam logic [3:0] CKOP_TRIM_RST = 4'h0;
	localparam logic [7:0] CKOP_RXCTRL_RST = 8'h10;

	// Oscillator mode encodings.
	localparam logic [3:0] CKOP_MODE_EXT = 4'h4;
	localparam logic [3:0] CKOP_MODE_XTAL = 4'hF;

	// Reference frequency and phase ticks per second (two per reference period).
	localparam int CKOP_REF_HZ = 16000000;
	localparam int CKOP_PHASE_HZ = 2 * CKOP_REF_HZ;

	// Output frequencies per rate code.
	localparam int CKOP_F1M = 1000000;
	localparam int CKOP_F2M = 2000000;
	localparam int CKOP_F4M = 4000000;
	localparam int CKOP_F8M = 8000000;
	localparam int CKOP_F16M = 16000000;
	localparam int CKOP_F250K = 250000;
	// Symbol rates times two, to keep 62.5 kHz whole.
	localparam int CKOP_SYM_BPSK0_X2 = 40000;
	localparam int CKOP_SYM_BPSK1_X2 = 80000;
	localparam int CKOP_SYM_OQPSK0_X2 = 50000;
	localparam int CKOP_SYM_OQPSK1_X2 = 125000;

	// Width of the half-period counter in phase ticks.
	localparam int CKOP_CNT_W = 10;

	// Rate select codes.
	localparam logic [2:0] CKOP_RATE_OFF = 3'h0;
	localparam logic [2:0] CKOP_RATE_SYM = 3'h7;

	// Programmed clock output configuration.
	typedef struct packed {
		logic [1:0] pad_io;
		logic [1:0] drive;
		logic sha_sel;
		logic [2:0] rate;
	} ckop_ctrl0_t;

	// Oscillator configuration.
	typedef struct packed {
		logic [3:0] mode;
		logic [3:0] trim;
	} ckop_osc_t;

endpackage : ckop_pkg

// >>> verilog/ckop_divider.sv
// Glitch-free divider that shapes the clock output pin from reference phase ticks.
// Assumes the tick, half count and run request come from logic on core_clk.
module ckop_divider #(
	parameter int CNT_W = 10
) (
	// Clock, reset and enable.
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic ce,
	// Reference phase tick and requested shape.
	input wire logic phase_tick,
	input wire logic [CNT_W-1:0] half_cnt,
	input wire logic run,
	input wire logic stretch,
	// Divided output.
	output logic clk_out
);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] half_q;
	logic out_q;
	logic expire;
	logic boundary;
	logic [CNT_W-1:0] reload;

	// A new shape is taken only at the end of a low phase, so no runt pulse reaches the pin.
	assign expire = phase_tick && (cnt_q == '0);
	assign boundary = expire && !out_q; // R13
	assign reload = boundary ? half_cnt - CNT_W'(1) + CNT_W'(stretch) : half_q - CNT_W'(1) + CNT_W'(stretch);

	// Count down each half period and toggle the output on expiry while run is set; with run clear a low output stays low.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cnt_q <= '0;
			half_q <= CNT_W'(1);
			out_q <= 1'b0;
		end else if (ce && phase_tick) begin
			if (expire) begin
				if (boundary) begin
					half_q <= half_cnt; // R13
					out_q <= run;
				end else begin
					out_q <= 1'b0;
				end
				cnt_q <= reload;
			end else begin
				cnt_q <= cnt_q - CNT_W'(1);
			end
		end
	end

	assign clk_out = out_q;

endmodule : ckop_divider

// >>> verilog/ckop_clock_output.sv
// Clock output prescaler control: register file for rate, drive and oscillator settings.
// Assumes register port, sleep state and modulation bits come from logic on core_clk.
////////////////////////////////////////////////////////////////////////////////

// Notes on behaviour
// R1: Divide 16 MHz reference to fixed or symbol rates.
// R2: Rate codes 0 off, 1..5 MHz, 6 250k, 7 symbol.
// R3: No deferral or rate zero: apply write at once.
// R4: Deferral with nonzero rate: apply at wake.
// R5: Active rate survives reset; field reads one.
// R6: Unrewritten field switches output to 1 MHz after sleep.
// R7: Host rewrites its old rate after each reset.
// R8: Drive field selects 2, 4, 6 or 8 mA.
// R9: Deferred-update bit resets to one.
// R10: Jitter acts on output, not transmitter.
// R11: Host turns output off or minimum drive when unused.
// R12: Oscillator mode and trim fields are configuration only.
// R13: Rate changes land on a clean output boundary.
module ckop_clock_output #(
	parameter int CNT_W = ckop_pkg::CKOP_CNT_W
) (
	// Clock, resets and enable.
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic trx_reset_req,
	input wire logic ce,
	// Register port.
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Reference, sleep and modulation state.
	input wire logic phase_tick,
	input wire logic sleep_active,
	input wire logic modulation_select,
	input wire logic sub_mode,
	// Clock output pin and its driver.
	output logic clock_output_pin,
	output logic clock_output_pin_oe,
	output logic [1:0] output_pin_drive_strength,
	output logic [1:0] pad_io_drive_strength,
	// Oscillator and jitter configuration.
	output logic [3:0] oscillator_mode_field,
	output logic [3:0] oscillator_trim_field,
	output logic jitter_enable
);

	////////////////////////////////////////////////////////////////////////////////
	// Half period of a rate code, in reference phase ticks.
	function automatic logic [CNT_W-1:0] ckop_half(input logic [2:0] rate, input logic bpsk_n, input logic sub);
		logic [CNT_W-1:0] h;
		h = CNT_W'(ckop_pkg::CKOP_PHASE_HZ / (2 * ckop_pkg::CKOP_F1M));
		case (rate)
			3'h1: h = CNT_W'(ckop_pkg::CKOP_PHASE_HZ / (2 * ckop_pkg::CKOP_F1M));
			3'h2: h = CNT_W'(ckop_pkg::CKOP_PHASE_HZ / (2 * ckop_pkg::CKOP_F2M));
			3'h3: h = CNT_W'(ckop_pkg::CKOP_PHASE_HZ / (2 * ckop_pkg::CKOP_F4M));
			3'h4: h = CNT_W'(ckop_pkg::CKOP_PHASE_HZ / (2 * ckop_pkg::CKOP_F8M));
			3'h5: h = CNT_W'(ckop_pkg::CKOP_PHASE_HZ / (2 * ckop_pkg::CKOP_F16M));
			3'h6: h = CNT_W'(ckop_pkg::CKOP_PHASE_HZ / (2 * ckop_pkg::CKOP_F250K));
			3'h7: begin
				case ({bpsk_n, sub})
					2'b00: h = CNT_W'(ckop_pkg::CKOP_PHASE_HZ / ckop_pkg::CKOP_SYM_BPSK0_X2);
					2'b01: h = CNT_W'(ckop_pkg::CKOP_PHASE_HZ / ckop_pkg::CKOP_SYM_BPSK1_X2);
					2'b10: h = CNT_W'(ckop_pkg::CKOP_PHASE_HZ / ckop_pkg::CKOP_SYM_OQPSK0_X2);
					default: h = CNT_W'(ckop_pkg::CKOP_PHASE_HZ / ckop_pkg::CKOP_SYM_OQPSK1_X2);
				endcase
			end
			default: h = CNT_W'(1);
		endcase
		return h;
	endfunction : ckop_half

	// Register index match, shared by the write strobes and the read multiplexer.
	function automatic logic ckop_hit(input logic [5:0] addr, input logic [5:0] idx);
		return addr == idx;
	endfunction : ckop_hit

	////////////////////////////////////////////////////////////////////////////////
	// Register state.
	ckop_pkg::ckop_ctrl0_t ctrl0_q;
	ckop_pkg::ckop_ctrl0_t ctrl0_wr;
	ckop_pkg::ckop_osc_t osc_q;
	logic [7:0] rxctrl_q;
	logic [2:0] active_rate_q;
	logic sleep_q;
	logic [7:0] rdata_q;
	logic oe_q;
	logic [1:0] drv_q;
	logic [1:0] padio_q;
	logic [3:0] mode_q;
	logic [3:0] trim_q;
	logic jit_q;
	logic [7:0] lfsr_q;

	// Decoded accesses and rate update conditions.
	logic wr_ctrl0;
	logic wr_osc;
	logic wr_rx;
	logic rate_now;
	logic wake;
	logic reg_rst;
	logic [7:0] rd_mux;
	logic [CNT_W-1:0] half_sel;
	logic stretch;
	logic hit_ctrl0;
	logic hit_osc;
	logic hit_rx;
	logic run_req;
	logic jit_on;

	assign reg_rst = !rstn || trx_reset_req;
	// One index match per register, used by both the writes and the reads.
	assign hit_ctrl0 = ckop_hit(reg_addr, ckop_pkg::CKOP_ADDR_CTRL0);
	assign hit_osc = ckop_hit(reg_addr, ckop_pkg::CKOP_ADDR_OSC);
	assign hit_rx = ckop_hit(reg_addr, ckop_pkg::CKOP_ADDR_RXCTRL);
	assign wr_ctrl0 = reg_wr_en && hit_ctrl0;
	assign wr_osc = reg_wr_en && hit_osc;
	assign wr_rx = reg_wr_en && hit_rx;
	assign ctrl0_wr = ckop_pkg::ckop_ctrl0_t'(reg_wdata);
	// Deferral only when the old deferred-update bit is set and the old rate is nonzero.
	assign rate_now = wr_ctrl0 && (!ctrl0_q.sha_sel || (ctrl0_q.rate == ckop_pkg::CKOP_RATE_OFF)); // R3 R4 R9
	// Leaving sleep is the falling edge of the sleep state.
	assign wake = sleep_q && !sleep_active;

	// Read multiplexer; unmapped addresses read zero.
	assign rd_mux = hit_ctrl0 ? 8'(ctrl0_q) :
		hit_osc ? 8'(osc_q) :
		hit_rx ? rxctrl_q : 8'h00;

	// Divider shape follows the active rate, never the register field.
	assign half_sel = ckop_half(active_rate_q, modulation_select, sub_mode); // R1 R2
	// Jitter stretches a half period by one tick on a pseudo-random pattern.
	assign jit_on = rxctrl_q[ckop_pkg::CKOP_JIT_BIT];
	assign stretch = jit_on && lfsr_q[0]; // R10
	// Rate code zero stops the divider at its next low boundary and holds the pin low.
	assign run_req = active_rate_q != ckop_pkg::CKOP_RATE_OFF; // R2

	////////////////////////////////////////////////////////////////////////////////
	// Register file; the reset procedure reloads it as power-on does.
	always_ff @(posedge core_clk) begin
		if (reg_rst) begin
			ctrl0_q <= '{pad_io: ckop_pkg::CKOP_PADIO_RST, drive: ckop_pkg::CKOP_DRV_RST,
				sha_sel: ckop_pkg::CKOP_SHA_RST, rate: ckop_pkg::CKOP_RATE_RST}; // R5 R8 R9
			osc_q <= '{mode: ckop_pkg::CKOP_MODE_RST, trim: ckop_pkg::CKOP_TRIM_RST}; // R12
			rxctrl_q <= ckop_pkg::CKOP_RXCTRL_RST;
		end else if (ce) begin
			if (wr_ctrl0) begin
				ctrl0_q <= ctrl0_wr; // R8
			end
			if (wr_osc) begin
				osc_q <= ckop_pkg::ckop_osc_t'(reg_wdata); // R12
			end
			if (wr_rx) begin
				rxctrl_q <= reg_wdata;
			end
		end
	end

	// Active rate shadow: only power-on reset loads it with rate one, so it survives the reset procedure.
	// A write that meets the reset procedure is lost, so the shadow keeps its rate then.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			active_rate_q <= ckop_pkg::CKOP_RATE_RST;
			sleep_q <= 1'b0;
		end else if (ce) begin
			sleep_q <= sleep_active;
			if (rate_now && !trx_reset_req) begin
				active_rate_q <= ctrl0_wr.rate; // R3
			end else if (wake) begin
				active_rate_q <= ctrl0_q.rate; // R4 R5 R6
			end
		end
	end

	// Registered read data and configuration outputs.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rdata_q <= 8'h00;
			oe_q <= 1'b0;
			drv_q <= ckop_pkg::CKOP_DRV_RST;
			padio_q <= ckop_pkg::CKOP_PADIO_RST;
			mode_q <= ckop_pkg::CKOP_MODE_RST;
			trim_q <= ckop_pkg::CKOP_TRIM_RST;
			jit_q <= 1'b0;
			lfsr_q <= 8'h01;
		end else if (ce) begin
			if (reg_rd_en) begin
				rdata_q <= rd_mux; // R5
			end
			oe_q <= 1'b1;
			drv_q <= ctrl0_q.drive; // R8
			padio_q <= ctrl0_q.pad_io;
			mode_q <= osc_q.mode; // R12
			trim_q <= osc_q.trim; // R12
			jit_q <= jit_on; // R10
			if (phase_tick) begin
				lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Prescaler; rate code zero holds the pin low.
	ckop_divider #(
		.CNT_W(CNT_W)
	) u_div (
		.core_clk(core_clk),
		.rstn(rstn),
		.ce(ce),
		.phase_tick(phase_tick),
		.half_cnt(half_sel),
		.run(run_req), // R2 R13
		.stretch(stretch),
		.clk_out(clock_output_pin)
	);

	assign reg_rdata = rdata_q;
	assign clock_output_pin_oe = oe_q;
	assign output_pin_drive_strength = drv_q;
	assign pad_io_drive_strength = padio_q;
	assign oscillator_mode_field = mode_q;
	assign oscillator_trim_field = trim_q;
	assign jitter_enable = jit_q;

endmodule : ckop_clock_output

// >>> tb/ckop_checker.sv
// Port checks of the clock output prescaler control.
// Assumes one core clock and reference phase ticks at least six cycles apart.
module ckop_checker (
	// Clock, resets and enable.
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic trx_reset_req,
	input wire logic ce,
	// Register port.
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Pin and configuration outputs.
	input wire logic clock_output_pin,
	input wire logic clock_output_pin_oe,
	input wire logic [1:0] output_pin_drive_strength,
	input wire logic [3:0] oscillator_mode_field,
	input wire logic [3:0] oscillator_trim_field,
	input wire logic jitter_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);

	// A write that lands, and a following cycle with no write or reload.
	wire logic wr_ok = ce && reg_wr_en && !trx_reset_req;
	wire logic calm = ce && !trx_reset_req && !reg_wr_en;
	wire logic hit_c0 = reg_addr == ckop_pkg::CKOP_ADDR_CTRL0;
	wire logic hit_osc = reg_addr == ckop_pkg::CKOP_ADDR_OSC;

	////////////////////////////////////////////////////////////////////////////////
	property p_drive; wr_ok && hit_c0 ##1 calm |=> output_pin_drive_strength == $past(reg_wdata[5:4], 2); endproperty
	a_drive:
	assert property (p_drive) else $error("drive strength does not follow its field");
	property p_mode; wr_ok && hit_osc ##1 calm |=> oscillator_mode_field == $past(reg_wdata[7:4], 2); endproperty
	a_mode:
	assert property (p_mode) else $error("oscillator mode does not follow its field");
	property p_trim; wr_ok && hit_osc ##1 calm |=> oscillator_trim_field == $past(reg_wdata[3:0], 2); endproperty
	a_trim:
	assert property (p_trim) else $error("oscillator trim does not follow its field");
	property p_jit; wr_ok && reg_addr == ckop_pkg::CKOP_ADDR_RXCTRL ##1 calm |=> jitter_enable == $past(reg_wdata[5], 2);
	endproperty
	a_jit:
	assert property (p_jit) else $error("jitter enable does not follow its bit");
	property p_rst_read; trx_reset_req ##1 (ce && reg_rd_en && hit_c0) |=> reg_rdata == 8'h19; endproperty
	a_rst_read:
	assert property (p_rst_read) else $error("control register reads wrong after reload");
	property p_oe; $past(rstn) |-> clock_output_pin_oe; endproperty
	a_oe:
	assert property (p_oe) else $error("clock output pin not driven");
	property p_high; $rose(clock_output_pin) |=> clock_output_pin [*4]; endproperty
	a_high:
	assert property (p_high) else $error("runt high pulse on clock output");
	property p_low; $fell(clock_output_pin) |=> !clock_output_pin [*4]; endproperty
	a_low:
	assert property (p_low) else $error("runt low pulse on clock output");
endmodule : ckop_checker

bind ckop_clock_output ckop_checker u_checker (.*);

// >>> tb/ckop_mcu_model.sv
// Microcontroller side: counts reference phase ticks per period of the clock output pin.
// Assumes pin and tick are sampled on the core clock.
module ckop_mcu_model (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rstn,
	// Observed pin and reference tick.
	input wire logic clock_output_pin,
	input wire logic phase_tick,
	// Last period in ticks and count of rising edges.
	output logic [15:0] period_q,
	output logic [15:0] rises_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic pin_q;
	logic [15:0] cnt_q;
	// Latch the tick count at each rising edge of the pin.
	always_ff @(posedge core_clk) begin
		pin_q <= clock_output_pin;
		cnt_q <= cnt_q + {15'h0000, phase_tick};
		if (!rstn) begin
			cnt_q <= 16'h0000;
			rises_q <= 16'h0000;
			period_q <= 16'h0000;
		end else if (clock_output_pin && !pin_q) begin
			period_q <= cnt_q;
			cnt_q <= {15'h0000, phase_tick};
			rises_q <= rises_q + 16'h0001;
		end
	end
endmodule : ckop_mcu_model

// >>> tb/testbench.sv
// Self-checking bench of the clock output prescaler control.
// Assumes the package, design and microcontroller model are compiled first.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0, rstn = 1'b0, trx_reset_req = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
	logic sleep_active = 1'b0, modulation_select = 1'b0, sub_mode = 1'b0, phase_tick = 1'b0, ce = 1'b1;
	logic [5:0] reg_addr = 6'h00;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, v;
	logic pin, oe, jit;
	logic [1:0] drv, padio;
	logic [3:0] mode, trim;
	logic [15:0] period, rises;
	logic [2:0] tick_q = 3'h0;
	int n_errors = 0, comparisons = 0, seed = 32'h2f1a, r0;

	ckop_clock_output uut (.core_clk(core_clk), .rstn(rstn), .trx_reset_req(trx_reset_req), .ce(ce),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .phase_tick(phase_tick), .sleep_active(sleep_active),
		.modulation_select(modulation_select), .sub_mode(sub_mode), .clock_output_pin(pin),
		.clock_output_pin_oe(oe), .output_pin_drive_strength(drv), .pad_io_drive_strength(padio),
		.oscillator_mode_field(mode), .oscillator_trim_field(trim), .jitter_enable(jit));
	ckop_mcu_model mcu (.core_clk(core_clk), .rstn(rstn), .clock_output_pin(pin), .phase_tick(phase_tick),
		.period_q(period), .rises_q(rises));

	////////////////////////////////////////////////////////////////////////////////
	// Core clock, and a reference phase tick every sixth cycle.
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		tick_q <= (tick_q == 3'h5) ? 3'h0 : tick_q + 3'h1;
		phase_tick <= tick_q == 3'h5;
	end

	// Compare, report and count.
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : chk

	// Register write and read, each two cycles long.
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		reg_wr_en <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr_en <= 1'b0;
		@(posedge core_clk);
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd_en <= 1'b0;
		@(posedge core_clk);
		chk("read data", reg_rdata, exp);
	endtask : rd

	// Expected output period in reference phase ticks for a rate code.
	function automatic logic [15:0] ticks(input logic [2:0] r);
		logic [15:0] sym [4] = '{16'h0640, 16'h0320, 16'h0500, 16'h0200};
		if (r == 3'h6) return 16'h0080;
		if (r == 3'h7) return sym[{modulation_select, sub_mode}];
		return 16'h0040 >> r;
	endfunction : ticks

	// Let three rising edges pass, then compare the measured period.
	task automatic meas(input logic [15:0] exp);
		int r;
		r = rises;
		for (int i = 0; i < 40000 && rises < r + 3; i++) @(posedge core_clk);
		chk("rises in time", (rises < r + 3) ? 16'h0000 : 16'h0001, 16'h0001);
		chk("period in ticks", period, exp);
	endtask : meas

	// One sleep cycle ending in a wake.
	task automatic nap();
		sleep_active <= 1'b1;
		repeat (20) @(posedge core_clk);
		sleep_active <= 1'b0;
		@(posedge core_clk);
	endtask : nap

	task automatic give_verdict();
		$display("errors %0d, comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		rd(ckop_pkg::CKOP_ADDR_CTRL0, 8'h19);
		rd(ckop_pkg::CKOP_ADDR_OSC, 8'hF0);
		rd(ckop_pkg::CKOP_ADDR_RXCTRL, 8'h10);
		rd(6'h3F, 8'h00);
		chk("drive", drv, 2'h1);
		chk("pin enable", oe, 1'b1);
		meas(ticks(3'h1));
		wr(ckop_pkg::CKOP_ADDR_CTRL0, 8'h01);
		for (int r = 1; r < 7; r++) begin
			v = 8'($random(seed));
			wr(ckop_pkg::CKOP_ADDR_CTRL0, {v[7:4], 1'b0, 3'(r)});
			meas(ticks(3'(r)));
			chk("drive", drv, v[5:4]);
			chk("pad drive", padio, v[7:6]);
		end
		modulation_select <= 1'b0;
		sub_mode <= 1'b1;
		wr(ckop_pkg::CKOP_ADDR_CTRL0, 8'h07);
		meas(ticks(3'h7));
		modulation_select <= 1'b1;
		@(posedge core_clk);
		meas(ticks(3'h7));
		wr(ckop_pkg::CKOP_ADDR_CTRL0, 8'h08);
		repeat (3500) @(posedge core_clk);
		r0 = rises;
		repeat (600) @(posedge core_clk);
		chk("rises while off", rises, r0[15:0]);
		chk("pin while off", pin, 1'b0);
		wr(ckop_pkg::CKOP_ADDR_CTRL0, 8'h0D);
		meas(ticks(3'h5));
		wr(ckop_pkg::CKOP_ADDR_CTRL0, 8'h0A);
		meas(ticks(3'h5));
		nap();
		meas(ticks(3'h2));
		trx_reset_req <= 1'b1;
		@(posedge core_clk);
		trx_reset_req <= 1'b0;
		rd(ckop_pkg::CKOP_ADDR_CTRL0, 8'h19);
		meas(ticks(3'h2));
		nap();
		meas(ticks(3'h1));
		wr(ckop_pkg::CKOP_ADDR_CTRL0, 8'h0C);
		nap();
		meas(ticks(3'h4));
		trx_reset_req <= 1'b1;
		@(posedge core_clk);
		trx_reset_req <= 1'b0;
		wr(ckop_pkg::CKOP_ADDR_CTRL0, 8'h0C);
		rd(ckop_pkg::CKOP_ADDR_CTRL0, 8'h0C);
		nap();
		meas(ticks(3'h4));
		ce <= 1'b0;
		repeat (2) @(posedge core_clk);
		r0 = rises;
		repeat (400) @(posedge core_clk);
		chk("rises while frozen", rises, r0[15:0]);
		ce <= 1'b1;
		v = 8'($random(seed));
		wr(ckop_pkg::CKOP_ADDR_OSC, v);
		repeat (2) @(posedge core_clk);
		chk("mode", mode, v[7:4]);
		chk("trim", trim, v[3:0]);
		wr(ckop_pkg::CKOP_ADDR_RXCTRL, 8'h30);
		repeat (2) @(posedge core_clk);
		chk("jitter", jit, 1'b1);
		rd(ckop_pkg::CKOP_ADDR_RXCTRL, 8'h30);
		give_verdict();
	end

	// Watchdog against a hang.
	initial begin
		repeat (60000) @(posedge core_clk);
		n_errors++;
		give_verdict();
	end
endmodule : testbench
